// ### rtl/ttr_pkg.sv
// Constants for the timer tick-rate selection block
package ttr_pkg;
    // Register map
    localparam logic [7:0] TTR_RATE_CTRL_ADDR = 8'h8e;
    localparam logic [7:0] TTR_RATE_CTRL_RST  = 8'h00;
    // Field positions in the rate control register
    localparam int TTR_T2_BIT = 5;
    localparam int TTR_T1_BIT = 4;
    localparam int TTR_T0_BIT = 3;
    // Fields that hold storage; other bits read as zero
    localparam logic [7:0] TTR_RW_MASK = 8'h38;
    // Slow rate divisor
    localparam int          TTR_DIV      = 12;
    localparam logic [3:0]  TTR_DIV_LAST = 4'(TTR_DIV - 1);
    localparam int          TTR_NUM      = 3;
endpackage

// ### rtl/ttr_tick_sel.sv
// One timer's increment enable selection
`timescale 1ns/1ns
module ttr_tick_sel
(
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic rst_b_in,
    // Selection
    input  wire logic full_rate_in,
    input  wire logic slow_tick_in,
    input  wire logic counter_mode_in,
    input  wire logic ext_fall_in,
    input  wire logic run_in,
    // Increment enable
    output logic      inc_en_out
);
    logic next_inc;

    always_comb
    begin
        if (!run_in)
            next_inc = 1'b0;
        else if (counter_mode_in)
            next_inc = ext_fall_in;                         // R8
        else
            next_inc = full_rate_in ? 1'b1 : slow_tick_in;  // R4 R5
    end

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            inc_en_out <= 1'b0;
        else
            inc_en_out <= next_inc;
    end
endmodule

// ### rtl/ttr_top.sv
// Timer tick-rate selection: rate control register, prescaler and per-timer enables
//
// Contract
// (R1) Register bit 5 picks Timer2 rate: 0 divides by 12, 1 every clock.
// (R2) Register bit 4 picks Timer1 rate: 0 divides by 12, 1 every clock.
// (R3) Register bit 3 picks Timer0 rate: 0 divides by 12, 1 every clock.
// (R4) Rate bit set: timer increments once on every clock.
// (R5) Rate bit clear: timer increments once per 12 clocks.
// (R6) Each timer's rate choice is independent of the others.
// (R7) All three rate bits reset to 0, divide-by-12.
// (R8) Rate applies in timer function; counter function counts pin falling edges.
// (R9) Free-running modulo-12 prescaler gives shared one-clock slow enable.
`timescale 1ns/1ns
module ttr_top
(
    // Clock and reset
    input  wire logic                          mclk_in,
    input  wire logic                          rst_b_in,
    // Special function register port
    input  wire logic [7:0]                    sfr_addr_in,
    input  wire logic [7:0]                    sfr_wdata_in,
    input  wire logic                          sfr_wr_in,
    output logic      [7:0]                    sfr_rdata_out,
    // Per-timer controls, bit i is timer i
    input  wire logic [ttr_pkg::TTR_NUM-1:0]   run_in,
    input  wire logic [ttr_pkg::TTR_NUM-1:0]   counter_mode_in,
    input  wire logic [ttr_pkg::TTR_NUM-1:0]   ext_pin_in,
    // Increment enables, bit i is timer i
    output logic      [ttr_pkg::TTR_NUM-1:0]   inc_en_out
);
    import ttr_pkg::*;

    //**********************************************************************
    // Rate control register
    //**********************************************************************
    logic [7:0] timer_tick_rate_control;
    logic       timer2_full_rate_select;
    logic       timer1_full_rate_select;
    logic       timer0_full_rate_select;

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            timer_tick_rate_control <= TTR_RATE_CTRL_RST;  // R7
        else if (sfr_wr_in && sfr_addr_in == TTR_RATE_CTRL_ADDR)
            timer_tick_rate_control <= sfr_wdata_in & TTR_RW_MASK;
    end

    assign timer2_full_rate_select = timer_tick_rate_control[TTR_T2_BIT];  // R1
    assign timer1_full_rate_select = timer_tick_rate_control[TTR_T1_BIT];  // R2
    assign timer0_full_rate_select = timer_tick_rate_control[TTR_T0_BIT];  // R3

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            sfr_rdata_out <= 8'h00;
        else if (sfr_addr_in == TTR_RATE_CTRL_ADDR)
            sfr_rdata_out <= timer_tick_rate_control;
        else
            sfr_rdata_out <= 8'h00;
    end

    a_reset_rate_zero: assert property (@(posedge mclk_in)  // R7
        $rose(rst_b_in) |-> timer_tick_rate_control == TTR_RATE_CTRL_RST)
        else $error("rate register not zero after reset");

    a_write_lands: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R1 R2 R3
        sfr_wr_in && sfr_addr_in == TTR_RATE_CTRL_ADDR |=>
            timer_tick_rate_control == ($past(sfr_wdata_in) & TTR_RW_MASK))
        else $error("rate register write did not land");

    a_hold_no_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R6
        !(sfr_wr_in && sfr_addr_in == TTR_RATE_CTRL_ADDR) |=> $stable(timer_tick_rate_control))
        else $error("rate register changed without a write");

    a_unused_bits_zero: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R1 R2 R3
        (timer_tick_rate_control & ~TTR_RW_MASK) == 8'h00)
        else $error("unimplemented rate register bits are set");

    a_read_answer: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R1 R2 R3
        1'b1 |=> sfr_rdata_out == (($past(sfr_addr_in) == TTR_RATE_CTRL_ADDR) ?
                                   $past(timer_tick_rate_control) : 8'h00))
        else $error("read data does not follow the addressed register");

    //**********************************************************************
    // Modulo-12 prescaler
    //**********************************************************************
    logic [3:0] presc;
    logic       slow_tick;

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            presc <= 4'h0;
        else if (presc == TTR_DIV_LAST)
            presc <= 4'h0;  // R9
        else
            presc <= presc + 4'h1;
    end

    assign slow_tick = (presc == TTR_DIV_LAST);  // R9

    a_presc_period: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R9
        slow_tick |=> !slow_tick [*8] ##1 !slow_tick ##1 !slow_tick ##1 !slow_tick ##1 slow_tick)
        else $error("slow tick period is not twelve");

    a_presc_range: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R9
        presc <= TTR_DIV_LAST)
        else $error("prescaler count out of range");

    //**********************************************************************
    // External pin synchronisers and falling-edge detect
    //**********************************************************************
    logic [TTR_NUM-1:0] pin_s1;
    logic [TTR_NUM-1:0] pin_s2;
    logic [TTR_NUM-1:0] pin_s3;
    logic [TTR_NUM-1:0] pin_fall;

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
        end
        else
        begin
            pin_s1 <= ext_pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    assign pin_fall = pin_s3 & ~pin_s2;  // R8

    a_pin_fall_single: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R8
        (pin_fall & $past(pin_fall)) == '0)
        else $error("pin fall detect wider than one clock");

    //**********************************************************************
    // Per-timer enable selection
    //**********************************************************************
    logic [TTR_NUM-1:0] full_rate;

    assign full_rate = {timer2_full_rate_select, timer1_full_rate_select, timer0_full_rate_select};

    genvar gi;
    generate
        for (gi = 0; gi < TTR_NUM; gi++)
        begin : g_sel
            ttr_tick_sel u_sel
            (
                .mclk_in         (mclk_in),
                .rst_b_in        (rst_b_in),
                .full_rate_in    (full_rate[gi]),  // R6
                .slow_tick_in    (slow_tick),
                .counter_mode_in (counter_mode_in[gi]),
                .ext_fall_in     (pin_fall[gi]),
                .run_in          (run_in[gi]),
                .inc_en_out      (inc_en_out[gi])
            );
        end
    endgenerate

    //**********************************************************************
    // Per-timer enable checks
    //**********************************************************************
    a_reset_outputs_zero: assert property (@(posedge mclk_in)  // R7
        $rose(rst_b_in) |-> inc_en_out == '0 && sfr_rdata_out == 8'h00 && presc == 4'h0)
        else $error("outputs or prescaler not cleared by reset");

    a_t0_full_rate: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R3
        run_in[0] && !counter_mode_in[0] && timer0_full_rate_select |=> inc_en_out[0])
        else $error("timer0 full rate enable missing");

    a_t1_full_rate: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R2
        run_in[1] && !counter_mode_in[1] && timer1_full_rate_select |=> inc_en_out[1])
        else $error("timer1 full rate enable missing");

    a_t2_full_rate: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R1
        run_in[2] && !counter_mode_in[2] && timer2_full_rate_select |=> inc_en_out[2])
        else $error("timer2 full rate enable missing");

    a_slow_rate_t0: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R5
        run_in[0] && !counter_mode_in[0] && !timer0_full_rate_select |=> inc_en_out[0] == $past(slow_tick))
        else $error("timer0 slow enable not tied to prescaler");

    a_slow_rate_t1: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R2 R5
        run_in[1] && !counter_mode_in[1] && !timer1_full_rate_select |=> inc_en_out[1] == $past(slow_tick))
        else $error("timer1 slow enable not tied to prescaler");

    a_slow_rate_t2: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R6
        run_in[2] && !counter_mode_in[2] && !timer2_full_rate_select |=> inc_en_out[2] == $past(slow_tick))
        else $error("timer2 slow enable not tied to prescaler");

    a_slow_no_pair: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R5
        (run_in[1] && !counter_mode_in[1] && !timer1_full_rate_select) [*2] |=>
            !(inc_en_out[1] && $past(inc_en_out[1])))
        else $error("timer1 slow enable on two clocks in a row");

    a_counter_mode: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R8
        run_in[1] && counter_mode_in[1] |=> inc_en_out[1] == $past(pin_fall[1]))
        else $error("counter mode does not follow pin falls");

    a_counter_mode_t0: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R8
        run_in[0] && counter_mode_in[0] |=> inc_en_out[0] == $past(pin_fall[0]))
        else $error("timer0 counter mode does not follow pin falls");

    a_run_off_quiet: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R4 R5
        1'b1 |=> (inc_en_out & ~$past(run_in)) == '0)
        else $error("enable raised for a stopped timer");

    a_full_every_clk: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R4
        (run_in[0] && !counter_mode_in[0] && timer0_full_rate_select) [*3] |=> inc_en_out[0] && $past(inc_en_out[0]))
        else $error("timer0 full rate not every clock");

    a_t1_every_clk: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R4
        (run_in[1] && !counter_mode_in[1] && timer1_full_rate_select) [*3] |=> inc_en_out[1] && $past(inc_en_out[1]))
        else $error("timer1 full rate not every clock");

    a_t2_every_clk: assert property (@(posedge mclk_in) disable iff (!rst_b_in)  // R4
        (run_in[2] && !counter_mode_in[2] && timer2_full_rate_select) [*3] |=> inc_en_out[2] && $past(inc_en_out[2]))
        else $error("timer2 full rate not every clock");
endmodule

// ### test/tb_top.sv
// Self-checking testbench for the timer tick-rate selection block
`timescale 1ns/1ns
module tb_top;
    import ttr_pkg::*;
    // ************************************************************
    // Stimulus and observation signals
    // ************************************************************
    logic               mclk_in;
    logic               rst_b_in;
    logic [7:0]         sfr_addr_in;
    logic [7:0]         sfr_wdata_in;
    logic               sfr_wr_in;
    logic [7:0]         sfr_rdata_out;
    logic [TTR_NUM-1:0] run_in;
    logic [TTR_NUM-1:0] counter_mode_in;
    logic [TTR_NUM-1:0] ext_pin_in;
    logic [TTR_NUM-1:0] inc_en_out;
    logic [7:0]         cnt [TTR_NUM];
    int                 miscompares;
    int                 num_checks;

    ttr_top i_ttr_top (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .sfr_addr_in(sfr_addr_in),
        .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rdata_out(sfr_rdata_out),
        .run_in(run_in), .counter_mode_in(counter_mode_in), .ext_pin_in(ext_pin_in),
        .inc_en_out(inc_en_out));

    always #4 mclk_in = ~mclk_in;
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t reg got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_count(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t count got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        sfr_addr_in  <= a;
        sfr_wdata_in <= d;
        sfr_wr_in    <= 1'b1;
        @(posedge mclk_in);
        sfr_wr_in    <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        sfr_addr_in <= a;
        @(posedge mclk_in);
        @(negedge mclk_in);
        d = sfr_rdata_out;
    endtask

    // Counts enable pulses of every timer over n cycles
    task automatic measure(input int n);
        for (int t = 0; t < TTR_NUM; t++) cnt[t] = 8'h00;
        repeat (n)
        begin
            @(negedge mclk_in);
            for (int t = 0; t < TTR_NUM; t++) cnt[t] = cnt[t] + 8'(inc_en_out[t]);
        end
    endtask

    task automatic stop_test();
        $display("miscompares=%0d num_checks=%0d", miscompares, num_checks);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        logic [7:0] rd;
        mclk_in         = 1'b0;
        rst_b_in        = 1'b0;
        sfr_addr_in     = 8'h00;
        sfr_wdata_in    = 8'h00;
        sfr_wr_in       = 1'b0;
        run_in          = 3'b111;
        counter_mode_in = 3'b000;
        ext_pin_in      = 3'b000;
        miscompares     = 0;
        num_checks      = 0;
        repeat (16) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        reg_read(TTR_RATE_CTRL_ADDR, rd);
        check_byte(rd, TTR_RATE_CTRL_RST);
        measure(24);
        for (int t = 0; t < TTR_NUM; t++) check_count(cnt[t], 8'd2);
        reg_write(TTR_RATE_CTRL_ADDR, 8'hff);
        reg_read(TTR_RATE_CTRL_ADDR, rd);
        check_byte(rd, TTR_RW_MASK);
        reg_read(8'h8f, rd);
        check_byte(rd, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            reg_write(TTR_RATE_CTRL_ADDR, 8'(i << TTR_T0_BIT));
            repeat (3) @(posedge mclk_in);
            measure(24);
            for (int t = 0; t < TTR_NUM; t++)
                check_count(cnt[t], i[t] ? 8'd24 : 8'd2);
        end
        @(posedge mclk_in);
        run_in <= 3'b101;
        repeat (3) @(posedge mclk_in);
        measure(24);
        check_count(cnt[0], 8'd24);
        check_count(cnt[1], 8'd0);
        check_count(cnt[2], 8'd24);
        @(posedge mclk_in);
        run_in          <= 3'b111;
        counter_mode_in <= 3'b011;
        repeat (3) @(posedge mclk_in);
        fork
            measure(60);
            repeat (4)
            begin
                @(posedge mclk_in);
                ext_pin_in[1:0] <= 2'b11;
                repeat (6) @(posedge mclk_in);
                ext_pin_in[1:0] <= 2'b00;
                repeat (5) @(posedge mclk_in);
            end
        join
        check_count(cnt[0], 8'd4);
        check_count(cnt[1], 8'd4);
        check_count(cnt[2], 8'd60);
        // Reset in mid-run brings every rate back to divide-by-12
        @(posedge mclk_in);
        rst_b_in        <= 1'b0;
        counter_mode_in <= 3'b000;
        repeat (16) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        reg_read(TTR_RATE_CTRL_ADDR, rd);
        check_byte(rd, TTR_RATE_CTRL_RST);
        measure(24);
        for (int t = 0; t < TTR_NUM; t++) check_count(cnt[t], 8'd2);
        stop_test();
    end
endmodule
